/* File: logic/usx_pkg.sv */
`default_nettype none
package usx_pkg;

  // ==========================================================
  // Register map, byte addresses on the APB.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ==========================================================
  // Frame formats and stop lengths.
  localparam logic [3:0] MODE_8N1 = 4'h0;
  localparam logic [3:0] MODE_7BIT = 4'h1;
  localparam logic [3:0] MODE_ODD = 4'h2;
  localparam logic [3:0] MODE_EVEN = 4'h3;
  localparam logic [3:0] MODE_ADDR = 4'h4;
  localparam logic [1:0] STOP_1 = 2'h0;
  localparam logic [1:0] STOP_1P5 = 2'h1;
  localparam logic [1:0] STOP_2 = 2'h2;

  // ==========================================================
  // Baud ticks per bit and receive sample points.
  localparam logic [5:0] TICKS_NORMAL = 6'h10;
  localparam logic [5:0] TICKS_FAST = 6'h04;
  localparam logic [5:0] SAMPLE_A = 6'h07;
  localparam logic [5:0] SAMPLE_B = 6'h08;
  localparam logic [5:0] SAMPLE_C = 6'h09;
  localparam logic [5:0] SAMPLE_FAST = 6'h02;
  localparam logic [5:0] EARLY_CHECK = 6'h03;
  localparam logic [3:0] LAST_BIT_7 = 4'h6;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam int STATUS_OVF_BIT = 3;

  // ==========================================================
  // Register layouts, reset values and states.
  typedef struct packed {
    logic tx_shifter_empty_irq_enable;
    logic tx_buffer_empty_irq_enable;
    logic [3:0] mode;
    logic [1:0] stop_sel;
    logic baud_speed_multiplier;
    logic rx_polarity_invert;
    logic tx_polarity_invert;
    logic rx_enable_bit;
    logic transmit_enable_bit;
    logic module_on;
  } usx_ctrl_type;

  typedef struct packed {
    logic summary_error_flag;
    logic rx_parity_error;
    logic rx_framing_error;
    logic rx_overflow;
    logic rx_available;
    logic tx_shifter_empty_flag;
    logic tx_buffer_empty_flag;
  } usx_status_type;

  typedef struct packed {
    logic parity_error;
    logic framing_error;
    logic ninth;
    logic [7:0] data;
  } usx_rx_char_type;

  localparam usx_ctrl_type CTRL_RESET = '0;
  localparam logic [15:0] BAUD_RESET = 16'h0000;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP}
    usx_tx_state_type;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP}
    usx_rx_state_type;

endpackage
`default_nettype wire

/* File: logic/usx_uart.sv */
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Transmit line idles at mark; start bit is space, stop bits are mark.
// R2 - Frame: start, seven or eight data bits, optional ninth bit, stops.
// R3 - Stop length selectable: one, one and a half, or two bits.
// R4 - Each bit lasts one baud period from a 16-bit divider.
// R5 - LSB first; transmitter and receiver share format and baud.
// R6 - Write while shifter idle moves the character straight into it.
// R7 - Queued character moves at stop start; its start follows stops.
// R8 - Polarity bit zero gives high-true output, one inverts it.
// R9 - Polarity change reaches the pin regardless of on and enable.
// R10 - Pin driven while enabled and active; released when idle.
// R11 - Buffer-empty flag set when enabled and nothing is queued.
// R12 - Buffer-empty flag ignores its enable; request needs the enable.
// R13 - Shifter-empty flag set only when shifter idle, nothing waiting.
// R14 - Enabled shifter-empty flag feeds the summary error request.
// R15 - Mode 0001 sends seven low bits, ignoring the top bit.
// R16 - Modes 0011 even and 0010 odd append computed parity.
// R17 - An 8-bit mode carries an address bit in ninth position.
// R18 - Software sets mode, baud, transmit enable and on to send.
// R19 - Software enables buffer-empty request only while data remains.
// R20 - Software writes further bytes only while buffer-empty reads one.
// R21 - Receiver samples at 4x or 16x; characters go into a FIFO.
// R22 - Receive FIFO holds two characters, read via receive buffer.
// R23 - Mode 0000 is plain 8-bit; address mode uses code 0100.
module usx_uart
  import usx_pkg::*;
#(
  parameter int BAUD_WIDTH = 16,
  parameter int RX_DEPTH = 2
)(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rx,
  output logic o_tx,
  output logic o_tx_oe,
  output logic o_tx_irq,
  output logic o_error_irq
);

  localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW+1)'(RX_DEPTH);

  // ==========================================================
  // Shared decoding.
  function automatic logic has_ninth(input logic [3:0] m);
    return (m == MODE_ODD) || (m == MODE_EVEN) || (m == MODE_ADDR); // R23
  endfunction

  function automatic logic [3:0] last_bit(input logic [3:0] m);
    return (m == MODE_7BIT) ? LAST_BIT_7 : LAST_BIT_8;
  endfunction

  function automatic logic [8:0] tx_frame(input logic [8:0] d,
                                          input logic [3:0] m);
    logic nb;
    nb = d[8];
    if (m == MODE_EVEN)
      nb = ^d[7:0];
    else if (m == MODE_ODD)
      nb = ~^d[7:0];
    return {nb, d[7:0]};
  endfunction

  function automatic logic [1:0] vote_weight(input logic [5:0] c,
                                             input logic fast);
    if (fast)
      return (c == SAMPLE_FAST) ? 2'h2 : 2'h0;
    return (c == SAMPLE_A || c == SAMPLE_B || c == SAMPLE_C) ?
      2'h1 : 2'h0;
  endfunction

  // ==========================================================
  // Register file and APB slave.
  usx_ctrl_type ctrl_ff, nxt_ctrl;
  logic [BAUD_WIDTH-1:0] baud_divisor_ff, nxt_baud_divisor;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic acc_done, tx_write, rx_pop, ovf_clear;
  usx_status_type status;
  usx_rx_char_type rx_top;

  assign acc_done = i_psel & i_penable & pready_ff;
  assign tx_write = acc_done & i_pwrite & (i_paddr == ADDR_TXDATA)
    & ctrl_ff.module_on & ctrl_ff.transmit_enable_bit;
  assign ovf_clear = acc_done & i_pwrite & (i_paddr == ADDR_STATUS)
    & i_pwdata[STATUS_OVF_BIT];

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_baud_divisor = baud_divisor_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    if (i_psel & i_penable & ~pready_ff)
    begin
      nxt_pready = 1'b1;
      nxt_pslverr = ~(i_paddr == ADDR_CTRL || i_paddr == ADDR_BAUD ||
        i_paddr == ADDR_TXDATA || i_paddr == ADDR_RXDATA ||
        i_paddr == ADDR_STATUS);
      case (i_paddr)
        ADDR_CTRL: nxt_prdata = 32'(ctrl_ff);
        ADDR_BAUD: nxt_prdata = 32'(baud_divisor_ff);
        ADDR_RXDATA: nxt_prdata = status.rx_available ? 32'(rx_top) : '0;
        ADDR_STATUS: nxt_prdata = 32'(status);
        default: nxt_prdata = '0;
      endcase
    end
    if (acc_done & i_pwrite)
    begin
      if (i_paddr == ADDR_CTRL)
        nxt_ctrl = usx_ctrl_type'(i_pwdata[$bits(usx_ctrl_type)-1:0]);
      if (i_paddr == ADDR_BAUD)
        nxt_baud_divisor = i_pwdata[BAUD_WIDTH-1:0];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_ff <= CTRL_RESET;
      baud_divisor_ff <= BAUD_WIDTH'(BAUD_RESET);
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      baud_divisor_ff <= nxt_baud_divisor;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ==========================================================
  // Baud generator shared by both directions.
  logic [BAUD_WIDTH-1:0] brg_cnt_ff, nxt_brg_cnt;
  logic baud_tick;
  logic [5:0] spb, stop_ticks;

  assign baud_tick = ctrl_ff.module_on & (brg_cnt_ff == baud_divisor_ff); // R4
  assign spb = ctrl_ff.baud_speed_multiplier ? TICKS_FAST
    : TICKS_NORMAL; // R21

  always_comb
  begin
    nxt_brg_cnt = brg_cnt_ff + 1'b1;
    if (~ctrl_ff.module_on | baud_tick)
      nxt_brg_cnt = '0;
    case (ctrl_ff.stop_sel) // R3
      STOP_1P5: stop_ticks = spb + (spb >> 1);
      STOP_2: stop_ticks = spb << 1;
      default: stop_ticks = spb;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      brg_cnt_ff <= '0;
    else
      brg_cnt_ff <= nxt_brg_cnt;
  end

  // ==========================================================
  // Transmitter.
  usx_tx_state_type tx_state_ff, nxt_tx_state;
  logic [8:0] transmit_shift_register_ff, nxt_tsr;
  logic [8:0] transmit_buffer_reg_ff, nxt_txbuf;
  logic tx_buf_full_ff, nxt_tx_buf_full, tx_next_ff, nxt_tx_next;
  logic [3:0] tx_bitn_ff, nxt_tx_bitn;
  logic [5:0] tx_tick_ff, nxt_tx_tick;
  logic tx_ff, nxt_tx, tx_oe_ff, nxt_tx_oe, tx_line, tx_bit_end;
  logic tx_irq_ff, nxt_tx_irq, err_irq_ff, nxt_err_irq, tx_done_now;

  assign tx_bit_end = baud_tick &
    (tx_tick_ff == ((tx_state_ff == TX_STOP) ? stop_ticks : spb) - 6'h01);
  assign tx_done_now = (tx_state_ff == TX_IDLE) |
    ((tx_state_ff == TX_STOP) & tx_bit_end & ~tx_next_ff);

  always_comb
  begin
    nxt_tx_state = tx_state_ff;
    nxt_tsr = transmit_shift_register_ff;
    nxt_txbuf = transmit_buffer_reg_ff;
    nxt_tx_buf_full = tx_buf_full_ff;
    nxt_tx_next = tx_next_ff;
    nxt_tx_bitn = tx_bitn_ff;
    nxt_tx_tick = baud_tick ? tx_tick_ff + 6'h01 : tx_tick_ff;
    if (tx_bit_end)
      nxt_tx_tick = '0;
    tx_line = 1'b1; // R1
    case (tx_state_ff)
      TX_IDLE: nxt_tx_tick = '0;
      TX_START:
      begin
        tx_line = 1'b0; // R1
        nxt_tx_bitn = '0;
        if (tx_bit_end)
          nxt_tx_state = TX_DATA;
      end
      TX_DATA, TX_NINTH:
      begin
        tx_line = transmit_shift_register_ff[0]; // R5
        if (tx_bit_end)
        begin
          nxt_tsr = transmit_shift_register_ff >> 1;
          nxt_tx_bitn = tx_bitn_ff + 4'h1;
          nxt_tx_state = TX_STOP;
          if (tx_state_ff == TX_DATA &&
              tx_bitn_ff == last_bit(ctrl_ff.mode)) // R15
          begin
            if (has_ninth(ctrl_ff.mode)) // R16 R17
              nxt_tx_state = TX_NINTH;
          end
          else if (tx_state_ff == TX_DATA)
            nxt_tx_state = TX_DATA; // R2
          if (nxt_tx_state == TX_STOP && tx_buf_full_ff)
          begin
            nxt_tsr = tx_frame(transmit_buffer_reg_ff, ctrl_ff.mode); // R7
            nxt_tx_buf_full = 1'b0;
            nxt_tx_next = 1'b1;
          end
        end
      end
      TX_STOP:
      begin
        if (tx_bit_end)
        begin
          nxt_tx_state = tx_next_ff ? TX_START : TX_IDLE; // R7
          nxt_tx_next = 1'b0;
        end
      end
      default: nxt_tx_state = TX_IDLE;
    endcase
    if (tx_write & ~tx_buf_full_ff)
    begin
      if (tx_done_now)
      begin
        nxt_tsr = tx_frame(i_pwdata[8:0], ctrl_ff.mode); // R6
        nxt_tx_state = TX_START;
        nxt_tx_tick = '0;
      end
      else if (nxt_tx_state == TX_STOP && ~nxt_tx_next)
      begin
        nxt_tsr = tx_frame(i_pwdata[8:0], ctrl_ff.mode); // R6
        nxt_tx_next = 1'b1;
      end
      else
      begin
        nxt_txbuf = i_pwdata[8:0];
        nxt_tx_buf_full = 1'b1;
      end
    end
    if (~ctrl_ff.module_on)
    begin
      nxt_tx_state = TX_IDLE;
      nxt_tx_buf_full = 1'b0;
      nxt_tx_next = 1'b0;
    end
    nxt_tx = tx_line ^ ctrl_ff.tx_polarity_invert; // R8 R9
    nxt_tx_oe = ctrl_ff.module_on & ctrl_ff.transmit_enable_bit
      & (tx_state_ff != TX_IDLE); // R10
    nxt_tx_irq = status.tx_buffer_empty_flag
      & ctrl_ff.tx_buffer_empty_irq_enable; // R12
    nxt_err_irq = status.summary_error_flag;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tx_state_ff <= TX_IDLE;
      transmit_shift_register_ff <= '0;
      transmit_buffer_reg_ff <= '0;
      tx_buf_full_ff <= 1'b0;
      tx_next_ff <= 1'b0;
      tx_bitn_ff <= '0;
      tx_tick_ff <= '0;
      tx_ff <= 1'b1;
      tx_oe_ff <= 1'b0;
      tx_irq_ff <= 1'b0;
      err_irq_ff <= 1'b0;
    end
    else
    begin
      tx_state_ff <= nxt_tx_state;
      transmit_shift_register_ff <= nxt_tsr;
      transmit_buffer_reg_ff <= nxt_txbuf;
      tx_buf_full_ff <= nxt_tx_buf_full;
      tx_next_ff <= nxt_tx_next;
      tx_bitn_ff <= nxt_tx_bitn;
      tx_tick_ff <= nxt_tx_tick;
      tx_ff <= nxt_tx;
      tx_oe_ff <= nxt_tx_oe;
      tx_irq_ff <= nxt_tx_irq;
      err_irq_ff <= nxt_err_irq;
    end
  end

  // ==========================================================
  // Receiver front end and receive FIFO.
  usx_rx_state_type rx_state_ff, nxt_rx_state;
  logic [7:0] receive_shift_register_ff, nxt_rsr;
  logic rx_ninth_ff, nxt_rx_ninth, rx_prev_ff, rx_in, rx_early_ff;
  logic nxt_rx_early, rx_val, rx_push, rx_ovf_ff, nxt_rx_ovf;
  logic [1:0] rx_votes_ff, nxt_rx_votes, votes_now;
  logic [5:0] rx_tick_ff, nxt_rx_tick;
  logic [3:0] rx_bitn_ff, nxt_rx_bitn;
  logic [PW-1:0] rx_wptr_ff, nxt_rx_wptr, rx_rptr_ff, nxt_rx_rptr;
  logic [PW:0] rx_count_ff, nxt_rx_count;
  usx_rx_char_type rx_mem_ff [RX_DEPTH];
  usx_rx_char_type nxt_rx_mem [RX_DEPTH];
  usx_rx_char_type rx_char;

  assign rx_in = i_rx ^ ctrl_ff.rx_polarity_invert;
  assign rx_top = rx_mem_ff[rx_rptr_ff];
  assign rx_pop = acc_done & ~i_pwrite & (i_paddr == ADDR_RXDATA)
    & (rx_count_ff != '0); // R22
  assign votes_now = rx_votes_ff + (baud_tick & rx_in ?
    vote_weight(rx_tick_ff, ctrl_ff.baud_speed_multiplier) : 2'h0);
  assign rx_val = votes_now >= 2'h2;

  always_comb
  begin
    status.tx_buffer_empty_flag = ctrl_ff.transmit_enable_bit
      & ~tx_buf_full_ff; // R11 R12
    status.tx_shifter_empty_flag = (tx_state_ff == TX_IDLE); // R13
    status.rx_available = (rx_count_ff != '0);
    status.rx_overflow = rx_ovf_ff;
    status.rx_framing_error = status.rx_available & rx_top.framing_error;
    status.rx_parity_error = status.rx_available & rx_top.parity_error;
    status.summary_error_flag = rx_ovf_ff | (status.tx_shifter_empty_flag
      & ctrl_ff.tx_shifter_empty_irq_enable); // R14
  end

  always_comb
  begin
    nxt_rx_state = rx_state_ff;
    nxt_rsr = receive_shift_register_ff;
    nxt_rx_ninth = rx_ninth_ff;
    nxt_rx_bitn = rx_bitn_ff;
    nxt_rx_early = rx_early_ff | (baud_tick & ~rx_in);
    nxt_rx_votes = votes_now;
    nxt_rx_tick = baud_tick ? rx_tick_ff + 6'h01 : rx_tick_ff;
    rx_push = 1'b0;
    rx_char.data = (last_bit(ctrl_ff.mode) == LAST_BIT_7) ?
      {1'b0, receive_shift_register_ff[7:1]} : receive_shift_register_ff;
    rx_char.ninth = rx_ninth_ff;
    rx_char.framing_error = ~rx_val;
    rx_char.parity_error = (ctrl_ff.mode == MODE_EVEN) ?
      ^{rx_char.data, rx_ninth_ff} :
      ((ctrl_ff.mode == MODE_ODD) & ~^{rx_char.data, rx_ninth_ff});
    if (baud_tick && rx_tick_ff == spb - 6'h01)
    begin
      nxt_rx_tick = '0;
      nxt_rx_votes = '0;
    end
    case (rx_state_ff)
      RX_IDLE:
      begin
        nxt_rx_tick = '0;
        nxt_rx_votes = '0;
        nxt_rx_early = 1'b0;
        nxt_rx_bitn = '0;
        if (ctrl_ff.rx_enable_bit & rx_prev_ff & ~rx_in)
          nxt_rx_state = RX_START;
      end
      RX_START:
      begin
        if (baud_tick && ~ctrl_ff.baud_speed_multiplier &&
            rx_tick_ff == EARLY_CHECK && ~rx_early_ff)
          nxt_rx_state = RX_IDLE;
        else if (baud_tick && rx_tick_ff == spb - 6'h01)
          nxt_rx_state = (rx_votes_ff >= 2'h2) ? RX_IDLE : RX_DATA; // R21
      end
      RX_DATA, RX_NINTH:
      begin
        if (baud_tick && rx_tick_ff == spb - 6'h01)
        begin
          nxt_rx_bitn = rx_bitn_ff + 4'h1;
          if (rx_state_ff == RX_NINTH)
          begin
            nxt_rx_ninth = rx_votes_ff >= 2'h2;
            nxt_rx_state = RX_STOP;
          end
          else
          begin
            nxt_rsr = {rx_votes_ff >= 2'h2,
              receive_shift_register_ff[7:1]}; // R5
            if (rx_bitn_ff == last_bit(ctrl_ff.mode))
              nxt_rx_state = has_ninth(ctrl_ff.mode) ? RX_NINTH : RX_STOP;
          end
        end
      end
      RX_STOP:
      begin
        if (baud_tick && rx_tick_ff == (ctrl_ff.baud_speed_multiplier ?
            SAMPLE_FAST : SAMPLE_C))
        begin
          rx_push = 1'b1; // R21
          nxt_rx_state = RX_IDLE;
        end
      end
      default: nxt_rx_state = RX_IDLE;
    endcase
    if (~ctrl_ff.module_on)
      nxt_rx_state = RX_IDLE;
    nxt_rx_mem = rx_mem_ff;
    nxt_rx_wptr = rx_wptr_ff;
    nxt_rx_rptr = rx_rptr_ff + PW'(rx_pop);
    nxt_rx_count = rx_count_ff - (PW+1)'(rx_pop);
    nxt_rx_ovf = rx_ovf_ff & ~ovf_clear;
    if (rx_push && rx_count_ff == DEPTH_C && ~rx_pop)
      nxt_rx_ovf = 1'b1; // R22
    else if (rx_push)
    begin
      nxt_rx_mem[rx_wptr_ff] = rx_char;
      nxt_rx_wptr = rx_wptr_ff + 1'b1;
      nxt_rx_count = nxt_rx_count + 1'b1;
    end
    if (~ctrl_ff.module_on)
    begin
      nxt_rx_wptr = '0;
      nxt_rx_rptr = '0;
      nxt_rx_count = '0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_state_ff <= RX_IDLE;
      receive_shift_register_ff <= '0;
      rx_ninth_ff <= 1'b0;
      rx_prev_ff <= 1'b1;
      rx_early_ff <= 1'b0;
      rx_votes_ff <= '0;
      rx_tick_ff <= '0;
      rx_bitn_ff <= '0;
      rx_wptr_ff <= '0;
      rx_rptr_ff <= '0;
      rx_count_ff <= '0;
      rx_ovf_ff <= 1'b0;
      for (int i = 0; i < RX_DEPTH; i++)
        rx_mem_ff[i] <= '0;
    end
    else
    begin
      rx_state_ff <= nxt_rx_state;
      receive_shift_register_ff <= nxt_rsr;
      rx_ninth_ff <= nxt_rx_ninth;
      rx_prev_ff <= rx_in;
      rx_early_ff <= nxt_rx_early;
      rx_votes_ff <= nxt_rx_votes;
      rx_tick_ff <= nxt_rx_tick;
      rx_bitn_ff <= nxt_rx_bitn;
      rx_wptr_ff <= nxt_rx_wptr;
      rx_rptr_ff <= nxt_rx_rptr;
      rx_count_ff <= nxt_rx_count;
      rx_ovf_ff <= nxt_rx_ovf;
      rx_mem_ff <= nxt_rx_mem;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_tx = tx_ff;
  assign o_tx_oe = tx_oe_ff;
  assign o_tx_irq = tx_irq_ff;
  assign o_error_irq = err_irq_ff;

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  property p_idle_mark;
    (tx_state_ff == TX_IDLE) |=> (o_tx != $past(ctrl_ff.tx_polarity_invert));
  endproperty
  a_idle_mark: assert property (p_idle_mark) // R8
    else $error("Idle line not at mark level.");

  property p_start_space;
    (tx_state_ff == TX_START) |=> (o_tx == $past(ctrl_ff.tx_polarity_invert));
  endproperty
  a_start_space: assert property (p_start_space) // R1
    else $error("Start bit not at space level.");

  property p_direct_load;
    (tx_write && tx_state_ff == TX_IDLE && ctrl_ff.module_on)
      |=> (tx_state_ff == TX_START) && !tx_buf_full_ff;
  endproperty
  a_direct_load: assert property (p_direct_load) // R6
    else $error("Write to idle shifter was not started.");

  property p_stop_follow;
    (tx_state_ff == TX_STOP && tx_next_ff && tx_bit_end &&
      ctrl_ff.module_on) |=> (tx_state_ff == TX_START) ##1 tx_oe_ff;
  endproperty
  a_stop_follow: assert property (p_stop_follow) // R7
    else $error("Queued character did not follow the stop bits.");

  property p_oe_idle;
    (tx_state_ff == TX_IDLE) [*2] |-> !o_tx_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) // R10
    else $error("Pin driven while transmitter idle.");

  property p_irq_gate;
    !ctrl_ff.tx_buffer_empty_irq_enable |=> !o_tx_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // R12
    else $error("Request raised with its enable clear.");

  property p_buf_busy;
    tx_buf_full_ff
      |-> (tx_state_ff != TX_IDLE) && !status.tx_buffer_empty_flag;
  endproperty
  a_buf_busy: assert property (p_buf_busy) // R11
    else $error("Character queued behind an idle shifter.");

  property p_tick_space;
    (baud_tick && baud_divisor_ff != '0 && $stable(baud_divisor_ff))
      |=> !baud_tick;
  endproperty
  a_tick_space: assert property (p_tick_space) // R4
    else $error("Baud ticks closer than the divisor allows.");

  property p_overflow;
    (rx_push && rx_count_ff == DEPTH_C && !rx_pop)
      |=> rx_ovf_ff && (rx_count_ff == DEPTH_C);
  endproperty
  a_overflow: assert property (p_overflow) // R22
    else $error("Full receive FIFO accepted a character.");

  c_back_to_back: cover property (tx_state_ff == TX_STOP && tx_next_ff);
  c_rx_full: cover property (rx_count_ff == DEPTH_C);
  c_parity: cover property (tx_state_ff == TX_NINTH);

endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Register-level tests of the serial port.
module tb;
  import usx_pkg::*;
  logic clk, rst, psel, pen, pwr, pready, perr, err;
  logic rx, tx, tx_oe, tx_irq, err_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int n_errors = 0, checks_done = 0, cycles = 0, n;
  logic [3:0] modes[4] = '{MODE_7BIT, MODE_EVEN, MODE_ODD, MODE_ADDR};
  logic [8:0] txd[4] = '{9'h000, 9'h007, 9'h007, 9'h155};
  logic [8:0] exp_f[4] = '{9'h180, 9'h107, 9'h007, 9'h155};
  usx_uart u_usx_uart(.i_ref_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .i_rx(rx),
    .o_tx(tx), .o_tx_oe(tx_oe), .o_tx_irq(tx_irq), .o_error_irq(err_irq));
  usx_peer #(.BIT(4)) u_usx_peer(.i_ref_clk(clk), .i_tx(tx), .o_rx(rx));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task frame_is(input logic [8:0] e);
    while (u_usx_peer.got_q.size() == 0)
      @(posedge clk);
    chk({23'h0, u_usx_peer.got_q.pop_front()}, {23'h0, e});
  endtask
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'(tx), 32'h1);
    chk(32'(tx_oe), 32'h0);
    rdc(ADDR_CTRL, 32'hFFFFFFFF, 32'(CTRL_RESET));
    wr(ADDR_BAUD, 32'h0);
    wr(ADDR_CTRL, 32'h27);
    rdc(ADDR_STATUS, 32'h3, 32'h3);
    wr(ADDR_TXDATA, 32'hA5);
    repeat (3) @(posedge clk);
    chk(32'(tx), 32'h0);
    chk(32'(tx_oe), 32'h1);
    wr(ADDR_TXDATA, 32'h3C);
    rdc(ADDR_STATUS, 32'h3, 32'h0);
    frame_is(9'h1A5);
    frame_is(9'h13C);
    repeat (4) @(posedge clk);
    chk(32'(tx_oe), 32'h0);
    rdc(ADDR_STATUS, 32'h3, 32'h3);
    wr(ADDR_CTRL, 32'h3027);
    repeat (2) @(posedge clk);
    chk(32'(tx_irq), 32'h1);
    chk(32'(err_irq), 32'h1);
    wr(ADDR_CTRL, 32'h27);
    repeat (2) @(posedge clk);
    chk(32'(tx_irq), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CTRL, {20'h0, modes[i], 8'h27});
      wr(ADDR_TXDATA, {23'h0, txd[i]});
      frame_is(exp_f[i]);
      repeat (8) @(posedge clk);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_CTRL, (s < 3) ? {24'h0, 2'(s), 6'h27} : 32'h7);
      wr(ADDR_TXDATA, 32'h0);
      n = 0;
      do
      begin
        @(posedge clk);
        if (tx_oe === 1'b1)
          n++;
      end
      while (n == 0 || tx_oe === 1'b1);
      chk(32'(n), (s < 3) ? 32'h28 + 32'(2 * s) : 32'hA0);
      u_usx_peer.got_q.delete();
    end
    wr(ADDR_CTRL, 32'h27);
    u_usx_peer.send(8'h96);
    u_usx_peer.send(8'h3B);
    u_usx_peer.send(8'hE1);
    repeat (4) @(posedge clk);
    rdc(ADDR_STATUS, 32'hC, 32'hC);
    rdc(ADDR_RXDATA, 32'h7FF, 32'h096);
    rdc(ADDR_RXDATA, 32'h7FF, 32'h03B);
    rdc(ADDR_RXDATA, 32'h7FF, 32'h000);
    wr(ADDR_STATUS, 32'h8);
    rdc(ADDR_STATUS, 32'hC, 32'h0);
    chk(32'(err_irq), 32'h0);
    wr(ADDR_BAUD, 32'h1);
    rdc(ADDR_BAUD, 32'hFFFF, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h0);
    chk(32'(err), 32'h1);
    wr(ADDR_CTRL, 32'h8);
    repeat (2) @(posedge clk);
    chk(32'(tx), 32'h0);
    wr(ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(tx), 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: testbench/usx_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Remote serial peer: decodes the transmit line, drives the receive line.
module usx_peer #(
  parameter int BIT = 4
)(
  input wire logic i_ref_clk,
  input wire logic i_tx,
  output var logic o_rx
);
  logic [8:0] got_q[$];
  logic [8:0] frame;
  initial
  begin
    o_rx = 1'b1;
    forever
    begin
      @(negedge i_tx);
      repeat (BIT / 2) @(posedge i_ref_clk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (BIT) @(posedge i_ref_clk);
        frame[i] = i_tx;
      end
      got_q.push_back(frame);
      wait (i_tx === 1'b1);
    end
  end
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      o_rx <= f[i];
      repeat (BIT) @(posedge i_ref_clk);
    end
  endtask
endmodule
`default_nettype wire
